/* dv/edtc_host_model.sv */
// Host model that drives the serial command port of the decoder
`timescale 1ns/1ps
module edtc_host_model
    import edtc_pkg::*;
(
    input wire logic clk,    // Core clock, paces the link
    output logic sclk,       // Serial clock, still between frames
    output logic cs_n,       // Chip select, active low
    output logic sdin,       // Serial data to the device
    output logic dc,         // Data (1) or command (0)
    input wire logic sdo,    // Read data from the device
    input wire logic sdo_oe  // Read data enable from the device
);
    // Four core cycles a half period give the 32 ns link clock
    localparam int HALF_CYC = 4;
    localparam int GAP_CYC = 12;

    // Idle link: deselected, clock low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdin = 1'b0;
        dc = 1'b0;
    end
    // Wait a number of core rising edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One byte MSB first, data moves only while the clock is low
    task automatic put(input logic [7:0] b, input logic d);
        for (int i = 7; i >= 0; i--) begin
            sdin <= b[i];
            dc <= d;
            tick(HALF_CYC);
            sclk <= 1'b1;
            tick(HALF_CYC);
            sclk <= 1'b0;
        end
    endtask
    // Deselect; stale data and mode flip so they cannot look valid
    task automatic deselect();
        tick(HALF_CYC);
        cs_n <= 1'b1;
        sdin <= ~sdin;
        dc <= ~dc;
        tick(GAP_CYC);
        @(negedge clk);
    endtask
    // Clock gate and analog supply are taken as on before any detect
    task automatic cmd(input logic [7:0] c, input int np,
                       input logic [15:0] p);
        @(posedge clk);
        cs_n <= 1'b0;
        tick(HALF_CYC);
        put(c, 1'b0);
        if (np > 0) put(p[15:8], 1'b1);
        if (np > 1) put(p[7:0], 1'b1);
        deselect();
    endtask
    // Read-back in the same frame, both bytes marked as data
    task automatic read16(output logic [15:0] v, output logic oe);
        @(posedge clk);
        cs_n <= 1'b0;
        tick(HALF_CYC);
        put(CMD_TEMP_RD, 1'b0);
        v = '0;
        oe = 1'b1;
        dc <= 1'b1;
        for (int i = 0; i < RD_BITS; i++) begin
            tick(HALF_CYC);
            sclk <= 1'b1;
            v = {v[14:0], sdo};
            oe = oe & sdo_oe;
            tick(HALF_CYC);
            sclk <= 1'b0;
        end
        deselect();
    endtask
endmodule

/* dv/edtc_top_test.sv */
// Self-checking bench for the detect and temperature decoder
`timescale 1ns/1ps
module edtc_top_test;
    import edtc_pkg::*;
    logic core_clk, nrst, rail_ok, supply_above;
    logic sclk, cs_n, sdin, dc, sdo, sdo_oe, busy, rail_res, supply_low;
    logic use_int, oe;
    logic [2:0] lvl;
    logic [7:0] src;
    logic [11:0] temp;
    int errors, tests_run;

    edtc_top DUT (.CORE_CLK(core_clk), .NRST(nrst), .SCLK(sclk),
        .CS_N(cs_n), .SDIN(sdin), .DC(dc), .HIGH_VOLTAGE_RAIL_OK(rail_ok),
        .LOGIC_SUPPLY_ABOVE(supply_above), .SDO(sdo), .SDO_OE(sdo_oe),
        .BUSY(busy), .RAIL_READY_RESULT(rail_res),
        .SUPPLY_LOW_RESULT(supply_low), .SUPPLY_LEVEL_SEL(lvl),
        .TEMP_SRC_SEL(src), .TEMP_USE_INTERNAL(use_int),
        .TEMP_VALUE(temp));
    edtc_host_model host (.clk(core_clk), .sclk(sclk), .cs_n(cs_n),
        .sdin(sdin), .dc(dc), .sdo(sdo), .sdo_oe(sdo_oe));

    // 250 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Reserved threshold codes leave the old one in place
    function automatic logic [2:0] exp_lvl(logic [2:0] c, old);
        return (c >= SUPPLY_LVL_MIN) ? c : old;
    endfunction
    // Busy width counted at falling edges, where it has settled
    task automatic run_det();
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 1000) begin
            @(negedge core_clk);
            n++;
        end
        chk("busy_len", 16'(n), 16'(DETECT_CYC));
    endtask
    // Watchdog, far beyond the expected run time
    initial begin
        #200000;
        errors++;
        close_out();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [2:0] lx;
        logic [7:0] v;
        logic [11:0] t;
        logic [15:0] r;
        logic b;
        nrst = 1'b0;
        rail_ok = 1'b0;
        supply_above = 1'b0;
        errors = 0;
        tests_run = 0;
        void'($urandom(32'h5d4de8d5));
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(negedge core_clk);
        chk("lvl_por", 16'(lvl), 16'(SUPPLY_LVL_POR));
        chk("src_por", 16'(src), 16'(TEMP_SRC_POR));
        chk("int_por", 16'(use_int), 16'h0);
        chk("temp_por", 16'(temp), 16'(TEMP_POR));
        chk("busy_por", 16'({busy, sdo_oe}), 16'h0);
        // Rail detection with both outcomes
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk) rail_ok <= k[0];
            fork
                host.cmd(CMD_RAIL_DETECT, 0, 16'h0);
                run_det();
            join
            chk("rail_res", 16'(rail_res), 16'(k[0]));
        end
        // Every threshold code, random supply level
        lx = SUPPLY_LVL_POR;
        for (int c = 0; c < 8; c++) begin
            b = 1'($urandom);
            @(posedge core_clk) supply_above <= b;
            fork
                host.cmd(CMD_SUPPLY_DETECT, 1, {5'h0, c[2:0], 8'h0});
                run_det();
            join
            lx = exp_lvl(c[2:0], lx);
            chk("lvl", 16'(lvl), 16'(lx));
            chk("supply_low", 16'(supply_low), 16'(!b));
        end
        // Source select: random, internal, random, back to default
        for (int k = 0; k < 4; k++) begin
            v = (k == 1) ? TEMP_SRC_INTERNAL : 8'($urandom);
            if (k == 3) v = TEMP_SRC_POR;
            host.cmd(CMD_TEMP_SRC, 1, {v, 8'h0});
            chk("src", 16'(src), 16'(v));
            chk("int", 16'(use_int), 16'(v == TEMP_SRC_INTERNAL));
        end
        // Temperature write then read back, extremes first
        for (int k = 0; k < 6; k++) begin
            t = (k == 0) ? 12'h000 : (k == 1) ? 12'hfff : 12'($urandom);
            host.cmd(CMD_TEMP_WR, 2, {t, 4'h0});
            chk("temp", 16'(temp), 16'(t));
            host.read16(r, oe);
            chk("rd", r, {t, TEMP_LO_PAD});
            chk("oe_on", 16'(oe), 16'h1);
            chk("oe_off", 16'(sdo_oe), 16'h0);
        end
        close_out();
    end
endmodule

/* hw/edtc_pkg.sv */
// Constants and types shared by the detect and temperature command decoder
package edtc_pkg;
    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] CMD_RAIL_DETECT = 8'h14;
    localparam logic [7:0] CMD_SUPPLY_DETECT = 8'h15;
    localparam logic [7:0] CMD_TEMP_SRC = 8'h18;
    localparam logic [7:0] CMD_TEMP_WR = 8'h1a;
    localparam logic [7:0] CMD_TEMP_RD = 8'h1b;

    // ****************************************************************
    // Fields and power-on values
    // ****************************************************************
    localparam logic [2:0] SUPPLY_LVL_MIN = 3'h3;
    localparam logic [2:0] SUPPLY_LVL_POR = 3'h4;
    localparam logic [7:0] TEMP_SRC_POR = 8'h48;
    localparam logic [7:0] TEMP_SRC_INTERNAL = 8'h80;
    localparam logic [11:0] TEMP_POR = 12'h7ff;
    localparam logic [3:0] TEMP_LO_PAD = 4'h0;

    // ****************************************************************
    // Serial framing and timing
    // ****************************************************************
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [4:0] RD_BITS = 5'h10;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int DETECT_TIME_NS = 2000;
    localparam int DETECT_CYC =
        (DETECT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [9:0] DETECT_CNT_MAX = 10'(DETECT_CYC - 1);

    typedef enum logic [1:0] {DET_IDLE, DET_RAIL, DET_SUPPLY} edtc_det_t;
endpackage

/* hw/edtc_sync.sv */
// Two flip-flop synchroniser for one pin input
`timescale 1ns/1ps
module edtc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,    // Core clock
    input wire logic nrst,   // Synchronous reset, active low
    input wire logic din,    // Asynchronous input
    output logic dout        // Synchronised level
);
    logic meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_q <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

/* hw/edtc_top.sv */
// Detect and temperature command decoder behind the serial host port
`timescale 1ns/1ps
module edtc_top
    import edtc_pkg::*;
(
    input wire logic CORE_CLK,            // Core clock, 250 MHz
    input wire logic NRST,                // Synchronous reset, active low
    input wire logic SCLK,                // Host serial clock
    input wire logic CS_N,                // Host chip select, active low
    input wire logic SDIN,                // Host serial data in
    input wire logic DC,                  // Data (1) or command (0)
    input wire logic HIGH_VOLTAGE_RAIL_OK, // Analog rail ready flag
    input wire logic LOGIC_SUPPLY_ABOVE,  // Supply above threshold flag
    output logic SDO,                     // Serial read data
    output logic SDO_OE,                  // Read data enable
    output logic BUSY,                    // Detection in progress
    output logic RAIL_READY_RESULT,       // Last rail detection result
    output logic SUPPLY_LOW_RESULT,       // Last supply detection result
    output logic [2:0] SUPPLY_LEVEL_SEL,  // Supply threshold code
    output logic [7:0] TEMP_SRC_SEL,      // Temperature source value
    output logic TEMP_USE_INTERNAL,       // Internal sensor selected
    output logic [11:0] TEMP_VALUE        // Temperature register
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic sclk_s, cs_n_s, sdin_s, dc_s, rail_s, supply_s;

    edtc_sync #(.RST_VAL(1'b0)) u_sclk (
        .clk(CORE_CLK), .nrst(NRST), .din(SCLK), .dout(sclk_s));
    edtc_sync #(.RST_VAL(1'b1)) u_cs (
        .clk(CORE_CLK), .nrst(NRST), .din(CS_N), .dout(cs_n_s));
    edtc_sync #(.RST_VAL(1'b0)) u_sdin (
        .clk(CORE_CLK), .nrst(NRST), .din(SDIN), .dout(sdin_s));
    edtc_sync #(.RST_VAL(1'b0)) u_dc (
        .clk(CORE_CLK), .nrst(NRST), .din(DC), .dout(dc_s));
    edtc_sync #(.RST_VAL(1'b0)) u_rail (
        .clk(CORE_CLK), .nrst(NRST), .din(HIGH_VOLTAGE_RAIL_OK),
        .dout(rail_s));
    edtc_sync #(.RST_VAL(1'b0)) u_supply (
        .clk(CORE_CLK), .nrst(NRST), .din(LOGIC_SUPPLY_ABOVE),
        .dout(supply_s));

    // ****************************************************************
    // Serial byte assembly
    // ****************************************************************
    logic sclk_prev_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic rise, fall, byte_done;
    logic [7:0] byte_val;

    // Edges are found on synchronised copies, so all pins share one delay
    assign rise = sclk_s && !sclk_prev_q && !cs_n_s;
    assign fall = !sclk_s && sclk_prev_q && !cs_n_s;
    assign byte_done = rise && (bit_cnt_q == BIT_LAST);
    assign byte_val = {shift_q, sdin_s};

    // Bit counter restarts whenever chip select is released
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            sclk_prev_q <= 1'b0;
            bit_cnt_q <= '0;
            shift_q <= '0;
        end else begin
            sclk_prev_q <= sclk_s;
            if (cs_n_s) begin
                bit_cnt_q <= '0;
            end else if (rise) begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
                shift_q <= byte_val[6:0];
            end
        end
    end

    // ****************************************************************
    // Command and parameter tracking
    // ****************************************************************
    logic [7:0] cmd_q;
    logic par_idx_q;
    logic is_par, par0, par1;

    assign is_par = byte_done && dc_s;
    assign par0 = is_par && !par_idx_q;
    assign par1 = is_par && par_idx_q;

    // Parameter bytes beyond the second are each taken as the second (par1 again)
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            cmd_q <= '0;
            par_idx_q <= 1'b0;
        end else if (byte_done) begin
            if (!dc_s) begin
                cmd_q <= byte_val;
                par_idx_q <= 1'b0;
            end else begin
                par_idx_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Detection sequencer
    // ****************************************************************
    edtc_det_t det_q;
    logic [9:0] det_cnt_q;
    logic start_rail, start_supply, det_end;

    assign start_rail = byte_done && !dc_s && byte_val == CMD_RAIL_DETECT
        && det_q == DET_IDLE;
    assign start_supply = par0 && cmd_q == CMD_SUPPLY_DETECT
        && det_q == DET_IDLE;
    assign det_end = det_q != DET_IDLE && det_cnt_q == DETECT_CNT_MAX;

    // A second start while busy is dropped; the host should wait anyway
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            det_q <= DET_IDLE;
            det_cnt_q <= '0;
            BUSY <= 1'b0;
        end else begin
            unique case (det_q)
                DET_IDLE: begin
                    det_cnt_q <= '0;
                    if (start_rail) begin
                        det_q <= DET_RAIL;
                        BUSY <= 1'b1;
                    end else if (start_supply) begin
                        det_q <= DET_SUPPLY;
                        BUSY <= 1'b1;
                    end
                end
                DET_RAIL, DET_SUPPLY: begin
                    if (det_end) begin
                        det_q <= DET_IDLE;
                        BUSY <= 1'b0;
                    end else begin
                        det_cnt_q <= det_cnt_q + 10'h1;
                    end
                end
            endcase
        end
    end

    // Results are sampled at the end only, then held on the result outputs
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            RAIL_READY_RESULT <= 1'b0;
            SUPPLY_LOW_RESULT <= 1'b0;
        end else if (det_end) begin
            if (det_q == DET_RAIL) begin
                RAIL_READY_RESULT <= rail_s;
            end else begin
                SUPPLY_LOW_RESULT <= !supply_s;
            end
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Threshold codes below the lowest level are refused, old value kept
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            SUPPLY_LEVEL_SEL <= SUPPLY_LVL_POR;
        end else if (start_supply && byte_val[2:0] >= SUPPLY_LVL_MIN) begin
            SUPPLY_LEVEL_SEL <= byte_val[2:0];
        end
    end

    // Source selection and its decoded flag
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            TEMP_SRC_SEL <= TEMP_SRC_POR;
            TEMP_USE_INTERNAL <= 1'b0;
        end else if (par0 && cmd_q == CMD_TEMP_SRC) begin
            TEMP_SRC_SEL <= byte_val;
            TEMP_USE_INTERNAL <= byte_val == TEMP_SRC_INTERNAL;
        end
    end

    // Temperature register, high byte first
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            TEMP_VALUE <= TEMP_POR;
        end else if (cmd_q == CMD_TEMP_WR) begin
            if (par0) begin
                TEMP_VALUE[11:4] <= byte_val;
            end else if (par1) begin
                TEMP_VALUE[3:0] <= byte_val[7:4];
            end
        end
    end

    // ****************************************************************
    // Temperature read-back
    // ****************************************************************
    logic [15:0] rd_shift_q;
    logic [4:0] rd_left_q;
    logic rd_load;

    assign rd_load = byte_done && !dc_s && byte_val == CMD_TEMP_RD;

    // Bits leave on falling edges so they are stable at the host's rise
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            rd_shift_q <= '0;
            rd_left_q <= '0;
            SDO <= 1'b0;
            SDO_OE <= 1'b0;
        end else if (cs_n_s || (byte_done && !dc_s && !rd_load)) begin
            rd_left_q <= '0;
            SDO_OE <= 1'b0;
        end else if (rd_load) begin
            rd_shift_q <= {TEMP_VALUE, TEMP_LO_PAD};
            rd_left_q <= RD_BITS;
            SDO_OE <= 1'b1;
        end else if (fall && rd_left_q != '0) begin
            SDO <= rd_shift_q[15];
            rd_shift_q <= {rd_shift_q[14:0], 1'b0};
            rd_left_q <= rd_left_q - 5'h1;
        end else if (rise && rd_left_q == '0) begin
            SDO_OE <= 1'b0;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_busy_run;
        BUSY [*8];
    endsequence

    a_rail_start: assert property (start_rail |=> BUSY ##0 s_busy_run)
        else $error("busy not raised after rail detect");
    a_supply_start: assert property (start_supply
        |=> BUSY ##0 s_busy_run)
        else $error("busy not raised after supply detect");
    a_busy_track: assert property (BUSY == (det_q != DET_IDLE))
        else $error("busy differs from detection state");
    a_busy_end: assert property (det_end |=> !BUSY)
        else $error("busy stayed high after detection");
    a_result_hold: assert property (BUSY && !det_end
        |=> $stable(RAIL_READY_RESULT) && $stable(SUPPLY_LOW_RESULT))
        else $error("result changed mid detection");
    a_level_legal: assert property (SUPPLY_LEVEL_SEL >= SUPPLY_LVL_MIN)
        else $error("threshold code not applicable");
    a_src_decode: assert property (TEMP_USE_INTERNAL
        == (TEMP_SRC_SEL == TEMP_SRC_INTERNAL))
        else $error("internal flag disagrees with source");
    a_temp_hi: assert property (par0 && cmd_q == CMD_TEMP_WR
        |=> TEMP_VALUE[11:4] == $past(byte_val))
        else $error("temperature high byte not stored");
    a_temp_lo: assert property (par1 && cmd_q == CMD_TEMP_WR
        |=> TEMP_VALUE[3:0] == $past(byte_val[7:4]))
        else $error("temperature low nibble not stored");
    a_read_load: assert property (rd_load
        |=> rd_shift_q == {$past(TEMP_VALUE), TEMP_LO_PAD}
        && SDO_OE)
        else $error("read-back not loaded");
endmodule
